/* File: rtl/gvc_top.sv */
// gateway value converter: value conversion, address mapping, master retry timing
`timescale 1ns/10ps
module gvc_top #(
   parameter int RESP_TIMEOUT_CYCLES = gvc_pkg::RESP_TIMEOUT_CY, // response timeout
   parameter int MS_CYCLES           = gvc_pkg::MS_CY            // cycles per millisecond
) (
   input  wire logic        sys_clk_i,    // system clock, 40 MHz
   input  wire logic        rst_i,        // synchronous reset, active high
   input  wire logic [3:0]  reg_addr_i,   // register index
   input  wire logic [31:0] reg_wdata_i,  // register write data
   input  wire logic        reg_wr_i,     // write strobe
   input  wire logic        reg_rd_i,     // read strobe
   output logic      [31:0] reg_rdata_o,  // read data, cycle after strobe
   input  wire logic        in_valid_i,   // input telegram arrived
   input  wire logic [31:0] in_value_i,   // input value (bit 0 for binary)
   output logic             out_send_o,   // output telegram pulse
   output logic      [31:0] out_value_o,  // output value
   input  wire logic        req_start_i,  // master request issued
   input  wire logic        resp_i,       // slave response received
   input  wire logic        ack_i,        // slave acknowledge received
   output logic             resend_o,     // resend the request pulse
   output logic             skip_page_o,  // skip page channels pulse
   output logic             req_busy_o,   // waiting for response
   output logic      [7:0]  fcode_o,      // resolved function code
   output logic      [15:0] paddr_o       // resolved protocol address
);
   // configuration registers
   logic [31:0] mode_ff, onval_ff, offval_ff, thresh_ff, pctlo_ff, pcthi_ff;
   logic [31:0] scale_ff, cycle_ff, acfg_ff, rdata_ff, outval_ff;
   logic        send_ff;                      // output pulse
   logic [31:0] cyc_ms_ff, cyc_sub_ff;        // cyclic timers
   logic [31:0] tmo_ff;                       // response timer
   logic [1:0]  retry_ff;                     // retries used
   logic        busy_ff, resend_ff, skip_ff;  // master state
   logic        skipped_ff;                   // sticky skip flag

   // decoded mode fields
   wire [1:0]  mode_w   = mode_ff[gvc_pkg::MODE_LSB +: 2];
   wire        on_act   = mode_ff[gvc_pkg::ONACT_BIT];
   wire        off_act  = mode_ff[gvc_pkg::OFFACT_BIT];
   wire        invert_w = mode_ff[gvc_pkg::INVERT_BIT];
   wire        outbin_w = mode_ff[gvc_pkg::OUTBIN_BIT];
   wire        cyc_en_w = mode_ff[gvc_pkg::CYCEN_BIT];
   wire [1:0]  intype_w = mode_ff[gvc_pkg::INTYPE_LSB +: 2];

   // map a threshold action to send flag and bit value
   function automatic logic [1:0] act_map(input logic [1:0] a);
      act_map = (a == 2'(gvc_pkg::GVC_ACT_ON))  ? 2'h3 :
                (a == 2'(gvc_pkg::GVC_ACT_OFF)) ? 2'h2 : 2'h0;
   endfunction

   // threshold comparison, signed
   wire        gt_w  = $signed(in_value_i) > $signed(thresh_ff);
   wire        eq_w  = in_value_i == thresh_ff;
   wire [1:0]  thr_w = gt_w ? act_map(mode_ff[gvc_pkg::HIACT_LSB +: 2]) :
                       eq_w ? act_map(mode_ff[gvc_pkg::EQACT_LSB +: 2]) :
                       act_map(mode_ff[gvc_pkg::LOACT_LSB +: 2]);
   // threshold refused for bit inputs and for the eight-byte signed input
   wire        thr_ok = outbin_w && intype_w != 2'(gvc_pkg::GVC_IN_BIN) &&
                        intype_w != 2'(gvc_pkg::GVC_IN_S64);

   // percent remap: lo + (hi-lo)*in/255, rounded to nearest
   wire signed [17:0] pspan = $signed({10'h0, pcthi_ff[7:0]}) -
                              $signed({10'h0, pctlo_ff[7:0]});
   wire signed [27:0] pprod = 28'(pspan * $signed({1'b0, in_value_i[7:0]}));
   wire signed [27:0] pround = pprod + (pprod < 0 ? -28'sh7F : 28'sh7F);
   wire signed [27:0] pquot  = pround / 28'shFF;
   wire [7:0]  pct_w = 8'(pquot + 28'($signed({20'h0, pctlo_ff[7:0]})));

   // scaling: signed input times 8.8 factor, full range, no clamping
   wire signed [63:0] sprod = $signed(in_value_i) * $signed(scale_ff);
   wire [31:0] scl_w = sprod[39:8];   // two's complement result unclamped
   // scaling only for word and eight-byte signed inputs, never binary or percent
   wire        scl_ok = intype_w == 2'(gvc_pkg::GVC_IN_WORD) ||
                        intype_w == 2'(gvc_pkg::GVC_IN_S64);

   // conversion result selection
   logic       conv_send;
   logic [31:0] conv_val;
   always_comb begin
      conv_send = 1'b0;
      conv_val  = outval_ff;
      case (mode_w)
         2'(gvc_pkg::GVC_BINARY): begin
            if (outbin_w) begin
               conv_send = 1'b1;
               conv_val  = {31'h0, in_value_i[0] ^ invert_w};
            end else if (in_value_i[0]) begin
               conv_send = on_act;
               conv_val  = onval_ff;
            end else begin
               conv_send = off_act;
               conv_val  = offval_ff;
            end
         end
         2'(gvc_pkg::GVC_THRESH): begin
            conv_send = thr_w[1] && thr_ok;
            conv_val  = {31'h0, thr_w[0]};
         end
         2'(gvc_pkg::GVC_PERCENT): begin
            conv_send = 1'b1;
            conv_val  = {24'h0, pct_w};
         end
         default: begin
            conv_send = !outbin_w && scl_ok;
            conv_val  = scl_w;
         end
      endcase
   end

   // cyclic repeat tick
   wire cyc_tick = cyc_en_w && cycle_ff != 32'h0 && cyc_ms_ff >= cycle_ff - 32'h1 &&
                   cyc_sub_ff == 32'(MS_CYCLES - 1);
   wire new_send = in_valid_i && conv_send;

   // address resolution
   wire [15:0] aval   = acfg_ff[gvc_pkg::ACFG_VAL_LSB +: 16];
   wire [1:0]  aconv  = acfg_ff[gvc_pkg::ACFG_CONV_LSB +: 2];
   wire        awr    = acfg_ff[gvc_pkg::ACFG_WR_BIT];
   wire        amult  = acfg_ff[gvc_pkg::ACFG_MULT_BIT];
   wire [16:0] aval17 = {1'b0, aval};
   wire [1:0]  dec_rt = aval17 >= gvc_pkg::DEC_HOLD  ? 2'(gvc_pkg::GVC_RT_HOLD) :
                        aval17 >= gvc_pkg::DEC_INREG ? 2'(gvc_pkg::GVC_RT_INREG) :
                        aval17 >= gvc_pkg::DEC_DISC  ? 2'(gvc_pkg::GVC_RT_DISC) :
                        2'(gvc_pkg::GVC_RT_COIL);
   wire [16:0] dec_base = dec_rt == 2'(gvc_pkg::GVC_RT_HOLD)  ? gvc_pkg::DEC_HOLD :
                          dec_rt == 2'(gvc_pkg::GVC_RT_INREG) ? gvc_pkg::DEC_INREG :
                          dec_rt == 2'(gvc_pkg::GVC_RT_DISC)  ? gvc_pkg::DEC_DISC :
                          gvc_pkg::DEC_COIL;
   wire [16:0] dec_idx  = aval17 - dec_base;                       // zero-based index
   // prefix: type in field, index 1..9999 in value
   wire [1:0]  rtype = aconv == 2'(gvc_pkg::GVC_CONV_DEC5) ? dec_rt :
                       acfg_ff[gvc_pkg::ACFG_TYPE_LSB +: 2];
   wire [15:0] paddr_w = aconv == 2'(gvc_pkg::GVC_CONV_DEC5) ? dec_idx[15:0] :
                         aconv == 2'(gvc_pkg::GVC_CONV_ZERO) ? aval :
                         aval - 16'h1;
   wire        aval_bad = (aconv != 2'(gvc_pkg::GVC_CONV_ZERO) && aval == 16'h0) ||
                          (aconv == 2'(gvc_pkg::GVC_CONV_DEC5) &&
                           dec_idx > gvc_pkg::DEC_SPAN - 17'h1) ||
                          (aconv == 2'(gvc_pkg::GVC_CONV_PREFIX) &&
                           aval17 > gvc_pkg::DEC_SPAN);
   logic [7:0] fc_w;
   always_comb begin
      case (rtype)
         2'(gvc_pkg::GVC_RT_COIL):
            fc_w = !awr ? gvc_pkg::FC_RD_COIL : amult ? gvc_pkg::FC_WM_COIL :
                   gvc_pkg::FC_WR_COIL;
         2'(gvc_pkg::GVC_RT_DISC):
            fc_w = awr ? gvc_pkg::FC_NONE : gvc_pkg::FC_RD_DISC;
         2'(gvc_pkg::GVC_RT_INREG):
            fc_w = awr ? gvc_pkg::FC_NONE : gvc_pkg::FC_RD_INREG;
         default:
            fc_w = !awr ? gvc_pkg::FC_RD_HOLD : amult ? gvc_pkg::FC_WM_HOLD :
                   gvc_pkg::FC_WR_HOLD;
      endcase
   end
   wire [7:0] fc_final = aval_bad ? gvc_pkg::FC_NONE : fc_w;

   // master timeout expiry
   wire tmo_hit = busy_ff && !resp_i && !ack_i && tmo_ff >= 32'(RESP_TIMEOUT_CYCLES - 1);

   // register read mux
   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr_i)
         gvc_pkg::REG_MODE:    rd_mux = mode_ff;
         gvc_pkg::REG_ONVAL:   rd_mux = onval_ff;
         gvc_pkg::REG_OFFVAL:  rd_mux = offval_ff;
         gvc_pkg::REG_THRESH:  rd_mux = thresh_ff;
         gvc_pkg::REG_PCTLO:   rd_mux = pctlo_ff;
         gvc_pkg::REG_PCTHI:   rd_mux = pcthi_ff;
         gvc_pkg::REG_SCALE:   rd_mux = scale_ff;
         gvc_pkg::REG_CYCLE:   rd_mux = cycle_ff;
         gvc_pkg::REG_ADDRCFG: rd_mux = acfg_ff;
         gvc_pkg::REG_ADDRRES: rd_mux = {8'h0, fc_final, paddr_w};
         gvc_pkg::REG_OUTVAL:  rd_mux = outval_ff;
         gvc_pkg::REG_MSTAT:   rd_mux = {27'h0, skipped_ff, retry_ff, busy_ff, 1'b0};
         default:              rd_mux = 32'h0;
      endcase
   end

   // register writes and read data
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         mode_ff <= gvc_pkg::MODE_RST;   onval_ff <= gvc_pkg::WORD_RST;
         offval_ff <= gvc_pkg::WORD_RST; thresh_ff <= gvc_pkg::WORD_RST;
         pctlo_ff <= gvc_pkg::WORD_RST;  pcthi_ff <= gvc_pkg::WORD_RST;
         scale_ff <= gvc_pkg::SCALE_RST; cycle_ff <= gvc_pkg::CYCLE_RST;
         acfg_ff <= gvc_pkg::WORD_RST;   rdata_ff <= gvc_pkg::WORD_RST;
      end else begin
         rdata_ff <= reg_rd_i ? rd_mux : 32'h0;
         if (reg_wr_i) begin
            case (reg_addr_i)
               gvc_pkg::REG_MODE:    mode_ff   <= reg_wdata_i;
               gvc_pkg::REG_ONVAL:   onval_ff  <= reg_wdata_i;
               gvc_pkg::REG_OFFVAL:  offval_ff <= reg_wdata_i;
               gvc_pkg::REG_THRESH:  thresh_ff <= reg_wdata_i;
               gvc_pkg::REG_PCTLO:   pctlo_ff  <= reg_wdata_i;
               gvc_pkg::REG_PCTHI:   pcthi_ff  <= reg_wdata_i;
               gvc_pkg::REG_SCALE:   scale_ff  <= reg_wdata_i;
               gvc_pkg::REG_CYCLE:   cycle_ff  <= reg_wdata_i;
               gvc_pkg::REG_ADDRCFG: acfg_ff   <= reg_wdata_i;
               default: ;
            endcase
         end
      end
   end

   // output value, send pulse and cyclic timers
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         outval_ff <= gvc_pkg::WORD_RST;
         send_ff   <= 1'b0;
         cyc_ms_ff <= 32'h0;
         cyc_sub_ff <= 32'h0;
      end else begin
         send_ff <= new_send || cyc_tick;
         if (new_send)
            outval_ff <= conv_val;
         if (!cyc_en_w || new_send || cyc_tick) begin              // restart cycle on send
            cyc_ms_ff <= 32'h0;
            cyc_sub_ff <= 32'h0;
         end else if (cyc_sub_ff == 32'(MS_CYCLES - 1)) begin
            cyc_sub_ff <= 32'h0;
            cyc_ms_ff <= cyc_ms_ff + 32'h1;
         end else
            cyc_sub_ff <= cyc_sub_ff + 32'h1;
      end
   end

   // master request timing and retries
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         tmo_ff <= 32'h0; retry_ff <= 2'h0; busy_ff <= 1'b0;
         resend_ff <= 1'b0; skip_ff <= 1'b0; skipped_ff <= 1'b0;
      end else begin
         resend_ff <= 1'b0;
         skip_ff   <= 1'b0;
         if (reg_wr_i && reg_addr_i == gvc_pkg::REG_MSTAT && reg_wdata_i[4])
            skipped_ff <= 1'b0;
         if (req_start_i && !busy_ff) begin
            busy_ff <= 1'b1; tmo_ff <= 32'h0; retry_ff <= 2'h0;
         end else if (busy_ff) begin
            if (resp_i)
               busy_ff <= 1'b0;
            else if (ack_i)
               tmo_ff <= 32'h0;
            else if (tmo_hit) begin
               tmo_ff <= 32'h0;
               if (retry_ff == gvc_pkg::RETRY_MAX) begin
                  busy_ff <= 1'b0;
                  skip_ff <= 1'b1;
                  skipped_ff <= 1'b1;                              // set wins over clear
               end else begin
                  retry_ff <= retry_ff + 2'h1;
                  resend_ff <= 1'b1;
               end
            end else
               tmo_ff <= tmo_ff + 32'h1;
         end
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign out_send_o  = send_ff;
   assign out_value_o = outval_ff;
   assign resend_o    = resend_ff;
   assign skip_page_o = skip_ff;
   assign req_busy_o  = busy_ff;
   assign fcode_o     = fc_final;
   assign paddr_o     = paddr_w;
endmodule // gvc_top

/* File: rtl/gvc_pkg.sv */
// package: constants, register map and types for the gateway value converter
package gvc_pkg;
   // register index map on the plain register port (byte address = index)
   localparam logic [3:0] REG_MODE      = 4'h0; // converter mode and options
   localparam logic [3:0] REG_ONVAL     = 4'h1; // on value / scene
   localparam logic [3:0] REG_OFFVAL    = 4'h2; // off value / scene
   localparam logic [3:0] REG_THRESH    = 4'h3; // threshold, signed
   localparam logic [3:0] REG_PCTLO     = 4'h4; // output for 0 percent
   localparam logic [3:0] REG_PCTHI     = 4'h5; // output for 100 percent
   localparam logic [3:0] REG_SCALE     = 4'h6; // scaling factor, signed 8.8
   localparam logic [3:0] REG_CYCLE     = 4'h7; // cycle time in milliseconds
   localparam logic [3:0] REG_ADDRCFG   = 4'h8; // address convention and value
   localparam logic [3:0] REG_ADDRRES   = 4'h9; // resolved function code and address
   localparam logic [3:0] REG_OUTVAL    = 4'hA; // last converted output
   localparam logic [3:0] REG_MSTAT     = 4'hB; // master request status

   // mode register field positions
   localparam int MODE_LSB      = 0;  // 2-bit converter function
   localparam int ONACT_BIT     = 2;  // send on value
   localparam int OFFACT_BIT    = 3;  // send off value
   localparam int INVERT_BIT    = 4;  // invert binary
   localparam int OUTBIN_BIT    = 5;  // output is single bit
   localparam int CYCEN_BIT     = 6;  // cyclic sending enabled
   localparam int HIACT_LSB     = 8;  // 2-bit higher action
   localparam int EQACT_LSB     = 10; // 2-bit match action
   localparam int LOACT_LSB     = 12; // 2-bit lower action
   localparam int INTYPE_LSB    = 14; // 2-bit input type

   // address config fields
   localparam int ACFG_VAL_LSB  = 0;  // 16-bit configured address
   localparam int ACFG_CONV_LSB = 16; // 2-bit convention
   localparam int ACFG_WR_BIT   = 18; // write access
   localparam int ACFG_MULT_BIT = 19; // multiple write
   localparam int ACFG_TYPE_LSB = 20; // 2-bit type for plain conventions

   // reset values
   localparam logic [31:0] MODE_RST  = 32'h0000_0000;
   localparam logic [31:0] WORD_RST  = 32'h0000_0000;
   localparam logic [31:0] CYCLE_RST = 32'h0000_03E8;
   localparam logic [31:0] SCALE_RST = 32'h0000_0100;

   // timing
   localparam int CLK_HZ          = 40_000_000;
   localparam int RESP_TIMEOUT_S  = 1;
   localparam int RESP_TIMEOUT_CY = CLK_HZ * RESP_TIMEOUT_S;
   localparam int MS_CY           = CLK_HZ / 1000;
   localparam logic [1:0] RETRY_MAX = 2'h2;

   // five-digit decimal bases
   localparam logic [16:0] DEC_COIL  = 17'h00001;
   localparam logic [16:0] DEC_DISC  = 17'h02711;
   localparam logic [16:0] DEC_INREG = 17'h07531;
   localparam logic [16:0] DEC_HOLD  = 17'h09C41;
   localparam logic [16:0] DEC_SPAN  = 17'h0270F;

   // function codes
   localparam logic [7:0] FC_RD_COIL  = 8'h01;
   localparam logic [7:0] FC_RD_DISC  = 8'h02;
   localparam logic [7:0] FC_RD_HOLD  = 8'h03;
   localparam logic [7:0] FC_RD_INREG = 8'h04;
   localparam logic [7:0] FC_WR_COIL  = 8'h05;
   localparam logic [7:0] FC_WR_HOLD  = 8'h06;
   localparam logic [7:0] FC_WM_COIL  = 8'h0F;
   localparam logic [7:0] FC_WM_HOLD  = 8'h10;
   localparam logic [7:0] FC_NONE     = 8'h00;

   typedef enum logic [1:0] {GVC_BINARY, GVC_THRESH, GVC_PERCENT, GVC_SCALING} gvc_mode_type;
   typedef enum logic [1:0] {GVC_ACT_NONE, GVC_ACT_ON, GVC_ACT_OFF} gvc_act_type;
   typedef enum logic [1:0] {GVC_IN_BIN, GVC_IN_PCT, GVC_IN_WORD, GVC_IN_S64} gvc_in_type;
   typedef enum logic [1:0] {GVC_CONV_DEC5, GVC_CONV_PREFIX, GVC_CONV_ZERO, GVC_CONV_ONE}
      gvc_conv_type;
   typedef enum logic [1:0] {GVC_RT_COIL, GVC_RT_DISC, GVC_RT_INREG, GVC_RT_HOLD} gvc_rt_type;
endpackage

/* File: dv/gvc_top_sva.sv */
// checker: port-level assertions for the gateway value converter
`timescale 1ns/10ps
module gvc_top_sva #(
   parameter int RESP_TIMEOUT_CYCLES = 20, // response timeout in cycles
   parameter int MS_CYCLES           = 4   // cycles per millisecond
) (
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   input wire logic [3:0]  reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic        in_valid_i,
   input wire logic [31:0] in_value_i,
   input wire logic        out_send_o,
   input wire logic [31:0] out_value_o,
   input wire logic        req_start_i,
   input wire logic        resp_i,
   input wire logic        ack_i,
   input wire logic        resend_o,
   input wire logic        skip_page_o,
   input wire logic        req_busy_o,
   input wire logic [7:0]  fcode_o,
   input wire logic [15:0] paddr_o
);
   logic [31:0] mode_ff; // shadow of the mode register
   logic [31:0] acfg_ff; // shadow of the address config
   logic [31:0] wcnt_ff; // cycles waited since last (re)start
   logic [1:0]  rcnt_ff; // resends since the request

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   // shadows follow the register writes at the same edge as the block
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         mode_ff <= 32'h0;
         acfg_ff <= 32'h0;
      end else if (reg_wr_i && reg_addr_i == gvc_pkg::REG_MODE) begin
         mode_ff <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == gvc_pkg::REG_ADDRCFG) begin
         acfg_ff <= reg_wdata_i;
      end
   end

   // wait counter restarts on a new request, an acknowledge or a resend
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || (req_start_i && !req_busy_o) || ack_i || resend_o || !req_busy_o) begin
         wcnt_ff <= 32'h0;
      end else begin
         wcnt_ff <= wcnt_ff + 32'h1;
      end
      if (rst_i || (req_start_i && !req_busy_o)) begin
         rcnt_ff <= 2'h0;
      end else if (resend_o) begin
         rcnt_ff <= rcnt_ff + 2'h1;
      end
   end

   a_busy_on_start: assert property (req_start_i && !req_busy_o |=> req_busy_o)
      else $error("busy not raised after request");
   a_resp_clears: assert property (req_busy_o && resp_i |=> !req_busy_o)
      else $error("busy kept after response");
   a_resend_time: assert property (resend_o |-> wcnt_ff + 2 >= RESP_TIMEOUT_CYCLES
      && wcnt_ff <= RESP_TIMEOUT_CYCLES + 1)
      else $error("resend not at the response timeout");
   a_no_early_retry: assert property (req_busy_o && wcnt_ff + 3 < RESP_TIMEOUT_CYCLES
      |-> !resend_o && !skip_page_o)
      else $error("retry before the restarted timeout");
   a_skip_after_two: assert property (skip_page_o |-> rcnt_ff == 2'h2)
      else $error("page skipped without two resends");
   a_bit_forward: assert property (in_valid_i && mode_ff[1:0] == 2'h0 && mode_ff[5]
      |=> out_send_o && out_value_o[0] == ($past(in_value_i[0]) ^ $past(mode_ff[4])))
      else $error("bit output not forwarded");
   a_send_cause: assert property (out_send_o && !mode_ff[6] && !$past(mode_ff[6])
      |-> $past(in_valid_i))
      else $error("send without input telegram");
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data outside read slot");
   a_zero_addr: assert property (acfg_ff[17:16] == 2'h2 |-> paddr_o == acfg_ff[15:0])
      else $error("zero-based address altered");
   a_dec_hold: assert property (acfg_ff[17:16] == 2'h0 && acfg_ff[15:0] >= 16'h9C41
      && acfg_ff[15:0] <= 16'hC34F && !acfg_ff[18]
      |-> fcode_o == 8'h03 && paddr_o == acfg_ff[15:0] - 16'h9C41)
      else $error("holding register decode wrong");
endmodule // gvc_top_sva

bind gvc_top gvc_top_sva #(.RESP_TIMEOUT_CYCLES(RESP_TIMEOUT_CYCLES), .MS_CYCLES(MS_CYCLES))
   u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i), .in_value_i(in_value_i),
   .out_send_o(out_send_o), .out_value_o(out_value_o), .req_start_i(req_start_i),
   .resp_i(resp_i), .ack_i(ack_i), .resend_o(resend_o), .skip_page_o(skip_page_o),
   .req_busy_o(req_busy_o), .fcode_o(fcode_o), .paddr_o(paddr_o));

/* File: dv/gvc_slave_model.sv */
// partner: serial slave that answers promptly, slowly with acknowledge, or never
`timescale 1ns/10ps
module gvc_slave_model (
   input  wire logic       clk_i,    // system clock
   input  wire logic       rst_i,    // synchronous reset
   input  wire logic       req_i,    // request sent by the master
   input  wire logic       resend_i, // request repeated by the master
   input  wire logic [1:0] mode_i,   // 0 silent, 1 slow with ack, 2 prompt
   output logic            resp_o,   // response pulse
   output logic            ack_o     // acknowledge pulse
);
   logic [5:0] cnt_ff; // cycles since the request
   logic       act_ff; // request pending

   // answer timing per mode; a silent slave never answers
   always_ff @(posedge clk_i) begin
      resp_o <= 1'b0;
      ack_o  <= 1'b0;
      if (rst_i) begin
         act_ff <= 1'b0;
         cnt_ff <= 6'h0;
      end else if (req_i || resend_i) begin
         act_ff <= 1'b1;
         cnt_ff <= 6'h0;
      end else if (act_ff) begin
         cnt_ff <= cnt_ff + 6'h1;
         if (mode_i == 2'h2 && cnt_ff == 6'h3) begin
            resp_o <= 1'b1;
            act_ff <= 1'b0;
         end
         if (mode_i == 2'h1 && cnt_ff == 6'hF) begin
            ack_o <= 1'b1; // slow slave buys time
         end
         if (mode_i == 2'h1 && cnt_ff == 6'h1E) begin
            resp_o <= 1'b1;
            act_ff <= 1'b0;
         end
      end
   end
endmodule // gvc_slave_model

/* File: dv/gateway_value_converter_tb_top.sv */
// testbench: directed scenarios for the gateway value converter
`timescale 1ns/10ps
module gateway_value_converter_tb_top;
   logic        sys_clk_i, rst_i, reg_wr_i, reg_rd_i, in_valid_i, req_start_i;
   logic [3:0]  reg_addr_i;
   logic [31:0] reg_wdata_i, in_value_i, reg_rdata_o, out_value_o;
   logic        out_send_o, resp_i, ack_i, resend_o, skip_page_o, req_busy_o;
   logic [7:0]  fcode_o;
   logic [15:0] paddr_o;
   logic [1:0]  slave_mode;
   int          err_total, cmp_count, r, s, n, cyc;
   logic [31:0] acfg_tbl [6] = '{32'h0000_9C44, 32'h0000_2711, 32'h0021_0002,
                                 32'h0006_0005, 32'h003F_0004, 32'h000E_FFFF};
   logic [23:0] aexp_tbl [6] = '{24'h03_0003, 24'h02_0000, 24'h04_0001,
                                 24'h05_0005, 24'h10_0003, 24'h0F_FFFF};

   gvc_top #(.RESP_TIMEOUT_CYCLES(20), .MS_CYCLES(4)) DUT (.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i),
      .in_value_i(in_value_i), .out_send_o(out_send_o), .out_value_o(out_value_o),
      .req_start_i(req_start_i), .resp_i(resp_i), .ack_i(ack_i), .resend_o(resend_o),
      .skip_page_o(skip_page_o), .req_busy_o(req_busy_o), .fcode_o(fcode_o), .paddr_o(paddr_o));
   gvc_slave_model u_slave (.clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_start_i),
      .resend_i(resend_o), .mode_i(slave_mode), .resp_o(resp_i), .ack_o(ack_i));

   // compare and count
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   // one-cycle register write
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b0;
   endtask
   // one-cycle read, data checked in the following cycle
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'b0;
      #1 chk(reg_rdata_o, e);
   endtask
   // input telegram, then the expected send and value
   task cv(input logic [31:0] v, input logic se, input logic [31:0] e);
      @(posedge sys_clk_i);
      in_value_i <= v;
      in_valid_i <= 1'b1;
      @(posedge sys_clk_i);
      in_valid_i <= 1'b0;
      #1 chk(out_send_o, se);
      if (se) chk(out_value_o, e);
   endtask
   // issue a request, then count resends and skips
   task req_run(input int cycles);
      @(posedge sys_clk_i);
      req_start_i <= 1'b1;
      @(posedge sys_clk_i);
      req_start_i <= 1'b0;
      #1 chk(req_busy_o, 1'b1);
      r = 0;
      s = 0;
      repeat (cycles) begin
         @(posedge sys_clk_i);
         #1 r += resend_o;
         s += skip_page_o;
      end
   endtask

   task t_regs;
      rd(gvc_pkg::REG_SCALE, 32'h0000_0100);
      rd(gvc_pkg::REG_CYCLE, 32'h0000_03E8);
      wr(4'hC, 32'hFFFF_FFFF);
      rd(4'hC, 32'h0);
   endtask
   task t_binary;
      wr(gvc_pkg::REG_ONVAL, 32'h64);
      wr(gvc_pkg::REG_OFFVAL, 32'h11);
      wr(gvc_pkg::REG_MODE, 32'h4);
      cv(32'h1, 1'b1, 32'h64);
      cv(32'h0, 1'b0, 32'h0);
      wr(gvc_pkg::REG_MODE, 32'h8);
      cv(32'h0, 1'b1, 32'h11);
      cv(32'h1, 1'b0, 32'h0);
      wr(gvc_pkg::REG_MODE, 32'h30);
      cv(32'h1, 1'b1, 32'h0);
      cv(32'h0, 1'b1, 32'h1);
      wr(gvc_pkg::REG_MODE, 32'h20);
      cv(32'h1, 1'b1, 32'h1);
   endtask
   task t_thresh;
      wr(gvc_pkg::REG_THRESH, 32'h5);
      wr(gvc_pkg::REG_MODE, 32'h8921);
      cv(32'h6, 1'b1, 32'h1);
      cv(32'h5, 1'b1, 32'h0);
      cv(32'hFFFF_FFF9, 1'b0, 32'h0);
      wr(gvc_pkg::REG_MODE, 32'h9221);
      cv(32'h6, 1'b1, 32'h0);
      cv(32'h5, 1'b0, 32'h0);
      cv(32'hFFFF_FFF9, 1'b1, 32'h1);
      wr(gvc_pkg::REG_MODE, 32'h4921);
      cv(32'h6, 1'b1, 32'h1);
      wr(gvc_pkg::REG_MODE, 32'hC921);
      cv(32'h6, 1'b0, 32'h0);
   endtask
   task t_percent_scale;
      wr(gvc_pkg::REG_PCTLO, 32'h33);
      wr(gvc_pkg::REG_PCTHI, 32'hCC);
      wr(gvc_pkg::REG_MODE, 32'h4002);
      cv(32'h0, 1'b1, 32'h33);
      cv(32'hFF, 1'b1, 32'hCC);
      cv(32'h80, 1'b1, 32'h80);
      wr(gvc_pkg::REG_SCALE, 32'h0A00);
      wr(gvc_pkg::REG_MODE, 32'h8003);
      cv(32'h7, 1'b1, 32'h46);
      cv(32'hFFFF_FFFD, 1'b1, 32'hFFFF_FFE2);
      wr(gvc_pkg::REG_MODE, 32'h4003);
      cv(32'h7, 1'b0, 32'h0);
   endtask
   task t_cyclic;
      wr(gvc_pkg::REG_CYCLE, 32'h2);
      wr(gvc_pkg::REG_MODE, 32'h44);
      cv(32'h1, 1'b1, 32'h64);
      n = 0;
      do begin
         @(posedge sys_clk_i);
         #1 n++;
      end while (out_send_o !== 1'b1 && n < 50);
      chk(n, 8);
      chk(out_value_o, 32'h64);
      rd(gvc_pkg::REG_OUTVAL, 32'h64);
      wr(gvc_pkg::REG_MODE, 32'h0);
   endtask
   task t_addr;
      for (int i = 0; i < 6; i++) begin
         wr(gvc_pkg::REG_ADDRCFG, acfg_tbl[i]);
         #1 chk({fcode_o, paddr_o}, aexp_tbl[i]);
         rd(gvc_pkg::REG_ADDRRES, {8'h0, aexp_tbl[i]});
      end
   endtask
   task t_master;
      slave_mode = 2'h0;
      req_run(90);
      chk(r, 2);
      chk(s, 1);
      rd(gvc_pkg::REG_MSTAT, 32'h18);
      wr(gvc_pkg::REG_MSTAT, 32'h10);
      rd(gvc_pkg::REG_MSTAT, 32'h08);
      slave_mode = 2'h1;
      req_run(60);
      chk(r, 0);
      chk(req_busy_o, 1'b0);
      slave_mode = 2'h2;
      req_run(10);
      chk(req_busy_o, 1'b0);
   endtask

   // print counts and verdict, then end the run
   task stop_test;
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // clock
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   // hang guard
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         stop_test();
      end
   end
   // main sequence
   initial begin
      {rst_i, reg_wr_i, reg_rd_i, in_valid_i, req_start_i} = 5'b10000;
      {reg_addr_i, reg_wdata_i, in_value_i} = '0;
      {err_total, cmp_count, cyc} = '0;
      slave_mode = 2'h0;
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_binary();
      t_thresh();
      t_percent_scale();
      t_cyclic();
      t_addr();
      t_master();
      stop_test();
   end
endmodule // gateway_value_converter_tb_top
